// file: core/cfp_defines.svh
// Constants for the calorimeter front-end pipeline
`ifndef CFP_DEFINES_SVH
`define CFP_DEFINES_SVH
`define CFP_NCH 20
`define CFP_CH_PER_TWR 4
`define CFP_NTWR 5
`define CFP_DEPTH 42
`define CFP_NBUF 4
`define CFP_CAP_W 2
`define CFP_RNG_W 3
`define CFP_ADC_W 10
`define CFP_RAW_W 15
`define CFP_VAL_W 15
`define CFP_LIN_W 16
`define CFP_ET_W 10
`define CFP_ET_AW 12
`define CFP_RANGE_SHIFT 4
`define CFP_ENERGY_W 19
`define CFP_SUM_W 21
`define CFP_ET_SHIFT 9
`define CFP_INT_LAT 3
`define CFP_BX_NS 132
`define CFP_CLK_NS 50
`define CFP_BX_CLKS (`CFP_BX_NS / `CFP_CLK_NS)
`define CFP_WP_W 6
`define CFP_WORD_W 5
`endif

// file: core/cfp_l2buf.sv
// Four second-level event buffers with free tracking
`timescale 1ns/1ps
`include "cfp_defines.svh"
module cfp_l2buf (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Fill side
  input wire logic i_wr,
  input wire cfp_pkg::cfp_frame_t i_wr_data,
  output logic [1:0] o_wr_idx,
  output logic o_full,
  // Release
  input wire logic [`CFP_NBUF-1:0] i_free_mask,
  output logic [`CFP_NBUF-1:0] o_busy,
  // Read side
  input wire logic [1:0] i_rd_idx,
  input wire logic [`CFP_WORD_W-1:0] i_rd_word,
  output cfp_pkg::cfp_lin_t o_rd_data
);
  cfp_pkg::cfp_frame_t mem_q [0:`CFP_NBUF-1];
  logic [`CFP_NBUF-1:0] busy_q;
  logic [`CFP_NBUF-1:0] busy_d;
  logic [1:0] free_idx;
  logic do_wr;

  // Lowest free buffer first
  assign free_idx = !busy_q[0] ? 2'h0 : !busy_q[1] ? 2'h1 : !busy_q[2] ? 2'h2 : 2'h3;
  assign o_full = &busy_q;
  assign o_wr_idx = free_idx;
  assign do_wr = i_ce && i_wr && !o_full;
  assign busy_d = (busy_q & ~i_free_mask) | (do_wr ? cfp_pkg::cfp_onehot(free_idx) : 4'h0);
  assign o_busy = busy_q;
  assign o_rd_data = mem_q[i_rd_idx][i_rd_word];

  // ----------------------------------------
  // State
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      busy_q <= 4'h0;
    end else if (i_ce) begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem_q[free_idx] <= i_wr_data;
    end
  end

  buf_store_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    do_wr |=> busy_q[$past(free_idx)])
    else $error("stored buffer not marked busy");
  buf_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_ce && busy_q[0] && !i_free_mask[0]) |=> busy_q[0])
    else $error("buffer dropped without release");
endmodule : cfp_l2buf

// file: core/cfp_lut.sv
// Loadable lookup memory with several registered read ports
`timescale 1ns/1ps
module cfp_lut #(
  parameter int AW = 15,
  parameter int DW = 16,
  parameter int NRD = 20
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Load port
  input wire logic i_wr,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read ports
  input wire logic i_rd_en,
  input wire logic [NRD-1:0][AW-1:0] i_raddr,
  output logic [NRD-1:0][DW-1:0] o_rdata
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // constants loaded
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && i_wr) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_ce && i_rd_en) begin
      for (int i = 0; i < NRD; i++) begin
        o_rdata[i] <= mem_q[i_raddr[i]];
      end
    end
  end
endmodule : cfp_lut

// file: core/cfp_pkg.sv
// Types shared by the calorimeter front-end pipeline
`include "cfp_defines.svh"
package cfp_pkg;
  typedef struct packed {
    logic [`CFP_CAP_W-1:0] cap;
    logic [`CFP_RNG_W-1:0] rng;
    logic [`CFP_ADC_W-1:0] adc;
  } cfp_raw_t;
  typedef struct packed {
    logic flag;
    logic [`CFP_VAL_W-1:0] val;
  } cfp_lin_t;
  typedef cfp_raw_t [`CFP_NCH-1:0] cfp_raw_arr_t;
  typedef cfp_lin_t [`CFP_NCH-1:0] cfp_frame_t;
  typedef logic [`CFP_NTWR-1:0][`CFP_ET_W-1:0] cfp_et_arr_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_SEND = 2'h1,
    RD_DONE = 2'h3
  } cfp_rd_state_t;

  function automatic logic [`CFP_NBUF-1:0] cfp_onehot(input logic [1:0] idx);
    cfp_onehot = 4'h1 << idx;
  endfunction : cfp_onehot
endpackage : cfp_pkg

// file: core/cfp_top.sv
// Calorimeter front-end pipeline: linearize, tower sums, level-1 pipe, level-2 buffers, readout
`timescale 1ns/1ps
`include "cfp_defines.svh"
module cfp_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Integrator samples
  input wire logic i_bx,
  input wire cfp_pkg::cfp_raw_arr_t i_raw,
  output logic [1:0] o_cap_sel,
  output logic o_cap_err,
  output logic o_rate_err,
  // First-level trigger
  output cfp_pkg::cfp_et_arr_t o_et,
  output logic o_et_valid,
  input wire logic i_l1_acc,
  input wire logic i_l1_rej,
  output logic o_l1_stored,
  output logic [1:0] o_l1_idx,
  output logic o_l1_ovf,
  output logic [`CFP_NBUF-1:0] o_buf_busy,
  // Second-level trigger
  input wire logic i_l2_acc,
  input wire logic i_l2_rej,
  input wire logic [1:0] i_l2_idx,
  // Readout
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output cfp_pkg::cfp_lin_t o_rd_data,
  output logic o_rd_last,
  output logic o_rd_idle,
  // Lookup loading
  input wire logic i_ld_wr,
  input wire logic i_ld_et,
  input wire logic [`CFP_RAW_W-1:0] i_ld_addr,
  input wire logic [`CFP_LIN_W-1:0] i_ld_data
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // flag selects the coarse scale
  function automatic logic [`CFP_ENERGY_W-1:0] lin_energy(input cfp_pkg::cfp_lin_t s);
    lin_energy = s.flag ? {s.val, 4'h0} : {4'h0, s.val};
  endfunction : lin_energy

  function automatic logic [`CFP_SUM_W-1:0] twr_sum(input cfp_pkg::cfp_frame_t f, input int t);
    logic [`CFP_SUM_W-1:0] acc;
    acc = '0;
    for (int c = 0; c < `CFP_CH_PER_TWR; c++) begin
      acc = `CFP_SUM_W'(acc + `CFP_SUM_W'(lin_energy(f[t * `CFP_CH_PER_TWR + c])));
    end
    twr_sum = acc;
  endfunction : twr_sum

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic v1_q;
  logic v2_q;
  logic [1:0] cap_q;
  logic cap_err_q;
  logic rate_err_q;
  logic [1:0] gap_q;
  logic [`CFP_NCH-1:0][`CFP_LIN_W-1:0] lin_rdata;
  cfp_pkg::cfp_frame_t lin_frame;
  logic [`CFP_NTWR-1:0][`CFP_ET_AW-1:0] et_addr;
  logic [`CFP_NTWR-1:0][`CFP_ET_W-1:0] et_rdata;
  cfp_pkg::cfp_frame_t [`CFP_DEPTH-1:0] ring_q;
  logic [`CFP_WP_W-1:0] wp_q;
  cfp_pkg::cfp_frame_t evict;
  logic bx_go;
  logic stage_go;
  logic l1_acc_w;
  logic l2_full;
  logic [1:0] l2_wr_idx;
  logic stored_q;
  logic ovf_q;
  logic [1:0] l1_idx_q;
  logic [1:0] cap_exp;
  logic cap_bad;
  cfp_pkg::cfp_rd_state_t state_q;
  logic [1:0] rd_idx_q;
  logic [`CFP_WORD_W-1:0] word_q;
  cfp_pkg::cfp_lin_t rd_data_q;
  cfp_pkg::cfp_lin_t buf_rd;
  logic start;
  logic hs;
  logic last_w;
  logic [1:0] buf_rd_idx;
  logic [`CFP_WORD_W-1:0] buf_rd_word;
  logic rej_ok;
  logic [`CFP_NBUF-1:0] free_mask;

  // ----------------------------------------
  // Crossing timing and integrator control
  // ----------------------------------------
  assign bx_go = i_ce && i_bx;
  assign stage_go = i_ce && v1_q;
  // samples carry the position picked three crossings ago
  assign cap_exp = 2'(cap_q - 2'(`CFP_INT_LAT));
  always_comb begin
    cap_bad = 1'b0;
    for (int c = 0; c < `CFP_NCH; c++) begin
      cap_bad = cap_bad | (i_raw[c].cap != cap_exp);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cap_q <= 2'h0;
      cap_err_q <= 1'b0;
      rate_err_q <= 1'b0;
      // Start saturated so the first strobe after reset is not flagged
      gap_q <= 2'h3;
    end else if (i_ce) begin
      if (i_bx) begin
        cap_q <= 2'(cap_q + 2'h1);
        cap_err_q <= cap_bad;
        rate_err_q <= gap_q < 2'(`CFP_BX_CLKS);
        gap_q <= 2'h1;
      end else if (gap_q != 2'h3) begin
        gap_q <= 2'(gap_q + 2'h1);
      end
    end
  end
  assign o_cap_sel = cap_q;
  assign o_cap_err = cap_err_q;
  assign o_rate_err = rate_err_q;

  // ----------------------------------------
  // Linearization and tower energy
  // ----------------------------------------
  // raw sample is the lookup address
  cfp_lut #(.AW(`CFP_RAW_W), .DW(`CFP_LIN_W), .NRD(`CFP_NCH)) u_lin (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_wr(i_ld_wr && !i_ld_et),
    .i_waddr(i_ld_addr),
    .i_wdata(i_ld_data),
    .i_rd_en(i_bx),
    .i_raddr(i_raw),
    .o_rdata(lin_rdata)
  );
  assign lin_frame = lin_rdata;

  // tower sums feed the energy lookup
  always_comb begin
    for (int t = 0; t < `CFP_NTWR; t++) begin
      et_addr[t] = `CFP_ET_AW'(twr_sum(lin_frame, t) >> `CFP_ET_SHIFT);
    end
  end

  cfp_lut #(.AW(`CFP_ET_AW), .DW(`CFP_ET_W), .NRD(`CFP_NTWR)) u_et (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_wr(i_ld_wr && i_ld_et),
    .i_waddr(i_ld_addr[`CFP_ET_AW-1:0]),
    .i_wdata(i_ld_data[`CFP_ET_W-1:0]),
    .i_rd_en(v1_q),
    .i_raddr(et_addr),
    .o_rdata(et_rdata)
  );
  assign o_et = et_rdata;
  assign o_et_valid = v2_q;

  // ----------------------------------------
  // Level-1 pipeline
  // ----------------------------------------
  assign evict = ring_q[wp_q];
  // decision applies to the crossing leaving now
  assign l1_acc_w = stage_go && i_l1_acc;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      wp_q <= '0;
      ring_q <= '0;
      stored_q <= 1'b0;
      ovf_q <= 1'b0;
      l1_idx_q <= 2'h0;
    end else if (i_ce) begin
      // one crossing per strobe, no stall
      v1_q <= i_bx;
      v2_q <= v1_q;
      stored_q <= l1_acc_w && !l2_full;
      ovf_q <= l1_acc_w && l2_full;
      if (l1_acc_w && !l2_full) begin
        l1_idx_q <= l2_wr_idx;
      end
      if (v1_q) begin
        ring_q[wp_q] <= lin_frame;
        wp_q <= (wp_q == `CFP_WP_W'(`CFP_DEPTH - 1)) ? '0 : `CFP_WP_W'(wp_q + 1'b1);
      end
    end
  end
  assign o_l1_stored = stored_q;
  assign o_l1_ovf = ovf_q;
  assign o_l1_idx = l1_idx_q;

  // ----------------------------------------
  // Level-2 buffers
  // ----------------------------------------
  // reject simply never writes the buffers
  // all 20 channels in one buffer frame
  cfp_l2buf u_l2 (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_wr(l1_acc_w),
    .i_wr_data(evict),
    .o_wr_idx(l2_wr_idx),
    .o_full(l2_full),
    .i_free_mask(free_mask),
    .o_busy(o_buf_busy),
    .i_rd_idx(buf_rd_idx),
    .i_rd_word(buf_rd_word),
    .o_rd_data(buf_rd)
  );

  // ----------------------------------------
  // Readout
  // ----------------------------------------
  assign start = i_ce && state_q == cfp_pkg::RD_IDLE && i_l2_acc && o_buf_busy[i_l2_idx];
  assign hs = i_ce && o_rd_valid && i_rd_ready;
  assign last_w = word_q == `CFP_WORD_W'(`CFP_NCH - 1);
  assign buf_rd_idx = start ? i_l2_idx : rd_idx_q;
  assign buf_rd_word = start ? '0 : `CFP_WORD_W'(word_q + 1'b1);
  // The buffer being read cannot be rejected under it, except by a reject in the same cycle as the accept that starts its read
  assign rej_ok = i_ce && i_l2_rej && !(state_q != cfp_pkg::RD_IDLE && i_l2_idx == rd_idx_q);
  // release on readout end or reject
  assign free_mask = (i_ce && state_q == cfp_pkg::RD_DONE ? cfp_pkg::cfp_onehot(rd_idx_q) : 4'h0)
    | (rej_ok ? cfp_pkg::cfp_onehot(i_l2_idx) : 4'h0);

  // block read, one word per handshake
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_q <= cfp_pkg::RD_IDLE;
      rd_idx_q <= 2'h0;
      word_q <= '0;
      rd_data_q <= '0;
    end else if (i_ce) begin
      case (state_q)
        cfp_pkg::RD_IDLE: begin
          if (start) begin
            state_q <= cfp_pkg::RD_SEND;
            rd_idx_q <= i_l2_idx;
            word_q <= '0;
            rd_data_q <= buf_rd;
          end
        end
        cfp_pkg::RD_SEND: begin
          if (hs && last_w) begin
            state_q <= cfp_pkg::RD_DONE;
          end else if (hs) begin
            word_q <= buf_rd_word;
            rd_data_q <= buf_rd;
          end
        end
        cfp_pkg::RD_DONE: begin
          state_q <= cfp_pkg::RD_IDLE;
        end
        default: begin
          state_q <= cfp_pkg::RD_IDLE;
        end
      endcase
    end
  end
  assign o_rd_valid = state_q == cfp_pkg::RD_SEND;
  assign o_rd_last = o_rd_valid && last_w;
  assign o_rd_data = rd_data_q;
  assign o_rd_idle = state_q == cfp_pkg::RD_IDLE;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // every strobe with the clock enable high enters the pipe
  bx_enters_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_ce && i_bx) |=> v1_q)
    else $error("crossing not taken");
  ring_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (stage_go && wp_q == 6'h29) |=> wp_q == 6'h00)
    else $error("ring pointer did not wrap");
  cap_step_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_ce && i_bx) |=> cap_q == 2'($past(cap_q) + 2'h1))
    else $error("capacitor set not advanced");
  et_timing_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_ce && v1_q) |=> o_et_valid)
    else $error("energy not delivered");
  l1_store_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (l1_acc_w && !l2_full) |=> (o_l1_stored && o_buf_busy[o_l1_idx]))
    else $error("accepted crossing not stored");
  l1_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (stage_go && i_l1_rej && !i_l1_acc) |=> !o_l1_stored)
    else $error("rejected crossing stored");
  rd_last_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (hs && o_rd_last) |=> (state_q == cfp_pkg::RD_DONE) ##1 (o_rd_idle || !$past(i_ce)))
    else $error("block read end wrong");
  rd_free_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_ce && state_q == cfp_pkg::RD_DONE && !l1_acc_w) |=> !o_buf_busy[$past(rd_idx_q)])
    else $error("buffer not released");
endmodule : cfp_top

// file: tb/cfp_top_tb.sv
// Self-checking bench for the front-end pipeline
`timescale 1ns/1ps
`include "cfp_defines.svh"
module cfp_top_tb;
  logic i_ref_clk, i_sys_rst, i_ce, i_bx, i_l1_acc, i_l1_rej, i_l2_acc, i_l2_rej, i_rd_ready, i_ld_wr, i_ld_et;
  logic o_cap_err, o_rate_err, o_et_valid, o_l1_stored, o_l1_ovf, o_rd_valid, o_rd_last, o_rd_idle, slow, clr;
  logic [1:0] i_l2_idx, o_cap_sel, o_l1_idx, dec_in, exp_cap;
  logic [3:0] o_buf_busy, busy;
  logic [5:0] cnt, last_idx;
  logic [14:0] i_ld_addr;
  logic [15:0] i_ld_data;
  cfp_pkg::cfp_raw_arr_t i_raw;
  cfp_pkg::cfp_et_arr_t o_et;
  cfp_pkg::cfp_lin_t o_rd_data;
  cfp_pkg::cfp_frame_t words;
  cfp_pkg::cfp_frame_t frames [64];
  logic [1:0] decs [64];
  int bufcx [4];
  int n_errors = 0;
  int cmp_count = 0;

  cfp_top DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_bx(i_bx), .i_raw(i_raw),
    .o_cap_sel(o_cap_sel), .o_cap_err(o_cap_err), .o_rate_err(o_rate_err), .o_et(o_et), .o_et_valid(o_et_valid),
    .i_l1_acc(i_l1_acc), .i_l1_rej(i_l1_rej), .o_l1_stored(o_l1_stored), .o_l1_idx(o_l1_idx),
    .o_l1_ovf(o_l1_ovf), .o_buf_busy(o_buf_busy), .i_l2_acc(i_l2_acc), .i_l2_rej(i_l2_rej), .i_l2_idx(i_l2_idx),
    .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .o_rd_last(o_rd_last),
    .o_rd_idle(o_rd_idle), .i_ld_wr(i_ld_wr), .i_ld_et(i_ld_et), .i_ld_addr(i_ld_addr), .i_ld_data(i_ld_data));

  cfp_trig_model model (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bx(i_bx && i_ce), .i_dec(dec_in),
    .o_l1_acc(i_l1_acc), .o_l1_rej(i_l1_rej), .i_slow(slow), .i_clr(clr), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .i_rd_last(o_rd_last), .o_rd_ready(i_rd_ready), .o_words(words),
    .o_count(cnt), .o_last_idx(last_idx));

  // ----------------------------
  // Helpers and scenarios
  // ----------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_word(input cfp_pkg::cfp_lin_t got, input cfp_pkg::cfp_lin_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  // Table contents are plain functions of the address, so reloading an entry is harmless
  function automatic logic [15:0] f_lin(input logic [14:0] a);
    f_lin = {a[0] ^ a[7], a ^ 15'h2A5C};
  endfunction : f_lin

  function automatic logic [9:0] f_et(input logic [11:0] a);
    f_et = a[9:0] ^ {a[11:10], 8'hC3};
  endfunction : f_et

  function automatic cfp_pkg::cfp_raw_arr_t mk_raw(input logic [1:0] cap, input int n, input logic bad);
    for (int c = 0; c < `CFP_NCH; c++) begin
      mk_raw[c] = {cap ^ {1'b0, bad && c == 5}, 3'(c), 10'(n * 37 + c * 11)};
    end
  endfunction : mk_raw

  task automatic load(input logic et, input logic [14:0] addr, input logic [15:0] data);
    @(posedge i_ref_clk);
    i_ld_wr <= 1'b1;
    i_ld_et <= et;
    i_ld_addr <= addr;
    i_ld_data <= data;
  endtask : load

  task automatic send_crossing(input int n, input logic [1:0] dec, input logic bad);
    cfp_pkg::cfp_raw_arr_t r;
    cfp_pkg::cfp_frame_t f;
    cfp_pkg::cfp_et_arr_t et;
    logic [`CFP_SUM_W-1:0] s;
    logic [11:0] a;
    logic [1:0] idx;
    logic take;
    int i;
    int old;
    r = mk_raw(2'(exp_cap + 2'h1), n, bad);
    for (int c = 0; c < `CFP_NCH; c++) begin
      f[c] = f_lin(r[c]);
      load(1'b0, r[c], f[c]);
    end
    for (int t = 0; t < `CFP_NTWR; t++) begin
      s = '0;
      for (int k = 0; k < `CFP_CH_PER_TWR; k++) begin
        i = t * `CFP_CH_PER_TWR + k;
        s = s + ({6'h00, f[i].val} << (f[i].flag ? `CFP_RANGE_SHIFT : 0));
      end
      a = s[`CFP_SUM_W-1:`CFP_ET_SHIFT];
      et[t] = f_et(a);
      load(1'b1, {3'h0, a}, {6'h00, et[t]});
    end
    frames[n] = f;
    decs[n] = dec;
    @(posedge i_ref_clk);
    i_ld_wr <= 1'b0;
    i_bx <= 1'b1;
    i_raw <= r;
    dec_in <= dec;
    @(posedge i_ref_clk);
    i_bx <= 1'b0;
    #1;
    exp_cap = 2'(exp_cap + 2'h1);
    chk(o_cap_sel, exp_cap);
    chk(o_cap_err, bad);
    chk(o_rate_err, 1'b0);
    @(posedge i_ref_clk);
    #1;
    chk(o_et_valid, 1'b1);
    chk(o_et, et);
    old = n - `CFP_DEPTH;
    take = old >= 0 && decs[old][1];
    chk(o_l1_stored, take && busy != 4'hF);
    chk(o_l1_ovf, take && busy == 4'hF);
    if (take && busy != 4'hF) begin
      for (int b = 3; b >= 0; b--) begin
        if (!busy[b]) idx = 2'(b);
      end
      chk(o_l1_idx, idx);
      busy[idx] = 1'b1;
      bufcx[idx] = old;
    end
    chk(o_buf_busy, busy);
  endtask : send_crossing

  task automatic test_read(input logic [1:0] b, input logic s);
    int w;
    @(posedge i_ref_clk);
    slow <= s;
    clr <= 1'b1;
    @(posedge i_ref_clk);
    clr <= 1'b0;
    i_l2_acc <= 1'b1;
    i_l2_idx <= b;
    @(posedge i_ref_clk);
    i_l2_acc <= 1'b0;
    // A reject aimed at the buffer under readout must not free it
    i_l2_rej <= 1'b1;
    @(posedge i_ref_clk);
    i_l2_rej <= 1'b0;
    #1;
    chk(o_buf_busy[b], 1'b1);
    w = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      w++;
    end while (w < 400 && !(o_rd_idle && cnt == 6'h14));
    chk(cnt, 6'h14);
    chk(last_idx, 6'h13);
    for (int c = 0; c < `CFP_NCH; c++) chk_word(words[c], frames[bufcx[b]][c]);
    busy[b] = 1'b0;
    chk(o_buf_busy, busy);
    $display("test read of buffer %0d done", b);
  endtask : test_read

  task automatic test_reject(input logic [1:0] b);
    @(posedge i_ref_clk);
    i_l2_rej <= 1'b1;
    i_l2_idx <= b;
    @(posedge i_ref_clk);
    i_l2_rej <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    busy[b] = 1'b0;
    chk(o_buf_busy, busy);
    // A second-level accept for a freed buffer must start nothing
    @(posedge i_ref_clk);
    i_l2_acc <= 1'b1;
    @(posedge i_ref_clk);
    i_l2_acc <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk(o_rd_valid, 1'b0);
    $display("test reject done");
  endtask : test_reject

  task automatic test_rate;
    @(posedge i_ref_clk);
    i_bx <= 1'b1;
    i_raw <= mk_raw(2'(exp_cap + 2'h1), 47, 1'b0);
    dec_in <= 2'h1;
    @(posedge i_ref_clk);
    i_raw <= mk_raw(2'(exp_cap + 2'h2), 48, 1'b0);
    @(posedge i_ref_clk);
    i_bx <= 1'b0;
    #1;
    exp_cap = 2'(exp_cap + 2'h2);
    chk(o_rate_err, 1'b1);
    chk(o_cap_err, 1'b0);
    chk(o_cap_sel, exp_cap);
    send_crossing(49, 2'h1, 1'b0);
    $display("test rate done");
  endtask : test_rate

  task automatic test_freeze;
    // Strobes while the clock enable is low must leave every state untouched
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    i_bx <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_ce <= 1'b1;
    i_bx <= 1'b0;
    #1;
    chk({o_cap_sel, o_rate_err, o_et_valid, o_buf_busy, o_rd_idle}, {exp_cap, 7'h01});
    send_crossing(50, 2'h1, 1'b0);
    $display("test freeze done");
  endtask : test_freeze

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------
  // Clock, sequence and watchdog
  // ----------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_bx = 1'b0;
    i_raw = '0;
    i_l2_acc = 1'b0;
    i_l2_rej = 1'b0;
    i_l2_idx = 2'h0;
    i_ld_wr = 1'b0;
    i_ld_et = 1'b0;
    i_ld_addr = 15'h0000;
    i_ld_data = 16'h0000;
    dec_in = 2'h1;
    slow = 1'b0;
    clr = 1'b0;
    exp_cap = 2'h0;
    busy = 4'h0;
    repeat (8) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk({o_cap_sel, o_buf_busy, o_rd_idle, o_rd_valid, o_et_valid, o_l1_stored}, 10'h008);
    chk(o_et, '0);
    $display("test reset done");
    // First five crossings accepted, so the fifth finds every buffer taken
    for (int n = 0; n < `CFP_DEPTH + 5; n++) send_crossing(n, (n < 5) ? 2'h2 : 2'h1, n == 10);
    $display("test pipeline done");
    repeat (200) @(posedge i_ref_clk);
    #1;
    chk(o_buf_busy, 4'hF);
    test_read(2'h2, 1'b1);
    test_read(2'h3, 1'b0);
    test_reject(2'h0);
    test_read(2'h1, 1'b0);
    test_rate;
    test_freeze;
    report_and_stop;
  end
endmodule : cfp_top_tb

// file: tb/cfp_trig_model.sv
// Trigger and readout-controller model facing the front-end pipeline
`timescale 1ns/1ps
`include "cfp_defines.svh"
module cfp_trig_model #(
  parameter int DEPTH = `CFP_DEPTH
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // First-level decisions, bit 1 accept and bit 0 reject
  input wire logic i_bx,
  input wire logic [1:0] i_dec,
  output logic o_l1_acc,
  output logic o_l1_rej,
  // Block read
  input wire logic i_slow,
  input wire logic i_clr,
  input wire logic i_rd_valid,
  input wire cfp_pkg::cfp_lin_t i_rd_data,
  input wire logic i_rd_last,
  output logic o_rd_ready,
  output cfp_pkg::cfp_frame_t o_words,
  output logic [5:0] o_count,
  output logic [5:0] o_last_idx
);
  // ----------------------------
  // Decision delay and block read
  // ----------------------------
  logic [DEPTH-1:0][1:0] dec_q;
  logic [1:0] phase_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      dec_q <= {DEPTH{2'h1}};
      o_l1_acc <= 1'b0;
      o_l1_rej <= 1'b0;
    end else begin
      o_l1_acc <= i_bx & dec_q[DEPTH-1][1];
      o_l1_rej <= i_bx & dec_q[DEPTH-1][0];
      if (i_bx) begin
        dec_q <= {dec_q[DEPTH-2:0], i_dec};
      end
    end
  end

  // block read, slow mode takes one word in four cycles
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_clr) begin
      o_count <= 6'h00;
      o_last_idx <= 6'h3F;
      phase_q <= 2'h0;
      o_rd_ready <= 1'b0;
      o_words <= '0;
    end else begin
      phase_q <= phase_q + 2'h1;
      o_rd_ready <= !i_slow || (phase_q == 2'h2);
      if (i_rd_valid && o_rd_ready) begin
        o_words[o_count] <= i_rd_data;
        o_count <= o_count + 6'h01;
        if (i_rd_last && o_last_idx == 6'h3F) begin
          o_last_idx <= o_count;
        end
      end
    end
  end
endmodule : cfp_trig_model
